// >>> shared/dtmg_defs.svh
`ifndef DTMG_DEFS_SVH
`define DTMG_DEFS_SVH

// Register byte addresses on APB.
`define DTMG_ADDR_HIGH_CODE  12'h000
`define DTMG_ADDR_LOW_CODE   12'h004
`define DTMG_ADDR_CONTROL    12'h008
`define DTMG_ADDR_STATUS     12'h00C
// Control register field positions.
`define DTMG_CTRL_MELODY_BIT 0
`define DTMG_CTRL_PORT_BIT   1
// Reset values.
`define DTMG_RST_CODE        8'h00
`define DTMG_RST_PORT_FF     1'b1
// Sine timing: one tone period is 23 * (code + 2) clocks.
`define DTMG_STEPS_PER_PER   23
`define DTMG_CODE_OFFSET     2
// Lowest code usable for the sine output, lowest for melody.
`define DTMG_SINE_MIN_CODE   8'h3C
`define DTMG_MELODY_MIN_CODE 8'h02
// Low group gain 2 dB down: 204/256 is close to 0.794.
`define DTMG_LOW_GAIN        8'hCC

`endif

// >>> shared/dtmg_pkg.sv
package dtmg_pkg;

  // APB request as it arrives at the slave.
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } dtmg_apb_req_t;

  // APB answer from the slave.
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } dtmg_apb_rsp_t;

  // Drive level and output enable of the shared port pin.
  typedef struct packed {
    logic pinOut;
    logic pinOe;
  } dtmg_pin_t;

  // Tone generator state.
  typedef enum logic [1:0] {
    DTMG_OFF    = 2'b00,
    DTMG_SINE   = 2'b01,
    DTMG_MELODY = 2'b10
  } dtmg_mode_t;

endpackage

// >>> rtl/dtmg_top.sv
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "dtmg_defs.svh"

// Summary of operation
// - Melody mode tri-states tone, drives square wave.
// - Square wave is high for 12 of 23 steps.
// - Melody accepts high codes 2 to 255.
// - Each code drives its own sine synthesizer.
// - Low group attenuated 2 dB before sum.
// - Zero code halts its synthesizer.
// - Both codes zero powers generator down.
// - Tone frequency is clock over 23(code+2).
// - Melody off: port line, tone enabled unless both codes zero.
// - Melody with zero high code holds pin high.
// - Idle or melody holds tone in tri-state.
module dtmg_top
  import dtmg_pkg::*;
#(
  parameter int unsigned DAC_WIDTH = 10
) (
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire dtmg_pkg::dtmg_apb_req_t apbReq,
  output var  dtmg_pkg::dtmg_apb_rsp_t apbRsp,
  input  wire logic                    melodyPortPinIn,
  output var  dtmg_pkg::dtmg_pin_t     melodyPortPin,
  output logic [DAC_WIDTH-1:0]         toneLevel,
  output logic                         toneOe,
  output logic                         genPowerOn
);

  import dtmg_pkg::*;

  // ********************************************************
  // Register bank
  // ********************************************************
  logic [7:0]  high_group_freq_code_q;
  logic [7:0]  low_group_freq_code_q;
  logic        melody_enable_bit_q;
  logic        portFf_q;
  dtmg_apb_rsp_t rsp_d;

  // Address decode and access strobes. The answer is registered, so
  // every access has one wait state: the first access cycle captures
  // the answer and the second, with pready high, completes it.
  wire logic accessPhase = apbReq.psel & apbReq.penable;
  wire logic captureRsp  = accessPhase & ~apbRsp.pready;
  wire logic wrStb       = accessPhase & apbReq.pwrite & apbRsp.pready;
  wire logic hitHigh     = apbReq.paddr == `DTMG_ADDR_HIGH_CODE;
  wire logic hitLow      = apbReq.paddr == `DTMG_ADDR_LOW_CODE;
  wire logic hitCtrl     = apbReq.paddr == `DTMG_ADDR_CONTROL;
  wire logic hitStat     = apbReq.paddr == `DTMG_ADDR_STATUS;
  wire logic hitAny      = hitHigh | hitLow | hitCtrl | hitStat;

  // Register writes take effect at the edge at which pready is seen
  // high, the same edge at which the master ends the transfer.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      high_group_freq_code_q <= `DTMG_RST_CODE;
      low_group_freq_code_q  <= `DTMG_RST_CODE;
      melody_enable_bit_q    <= 1'b0;
      portFf_q               <= `DTMG_RST_PORT_FF;
    end else if (wrStb) begin
      if (hitHigh) high_group_freq_code_q <= apbReq.pwdata[7:0];
      if (hitLow)  low_group_freq_code_q  <= apbReq.pwdata[7:0];
      if (hitCtrl) begin
        melody_enable_bit_q <= apbReq.pwdata[`DTMG_CTRL_MELODY_BIT];
        portFf_q            <= apbReq.pwdata[`DTMG_CTRL_PORT_BIT];
      end
    end
  end

  // ********************************************************
  // Synthesizers
  // ********************************************************
  dtmg_mode_t mode_q;
  logic [7:0] codes [2];
  logic [5:0] phase_q [2];
  logic [8:0] stepCnt_q [2];
  logic       stepTick [2];
  logic signed [7:0] sineVal [2];

  assign codes[0] = high_group_freq_code_q;
  assign codes[1] = low_group_freq_code_q;

  // 23-step signed sine table, amplitude 127.
  function automatic logic signed [7:0] sineLut(input logic [5:0] idx);
    logic signed [7:0] v;
    v = 8'sh00;
    case (idx)
      6'd0:  v = 8'sh00;  6'd1:  v = 8'sh22;  6'd2:  v = 8'sh41;
      6'd3:  v = 8'sh5B;  6'd4:  v = 8'sh6F;  6'd5:  v = 8'sh7B;
      6'd6:  v = 8'sh7F;  6'd7:  v = 8'sh79;  6'd8:  v = 8'sh6A;
      6'd9:  v = 8'sh54;  6'd10: v = 8'sh38;  6'd11: v = 8'sh11;
      6'd12: v = 8'shEF;  6'd13: v = 8'shC8;  6'd14: v = 8'shAC;
      6'd15: v = 8'sh96;  6'd16: v = 8'sh87;  6'd17: v = 8'sh81;
      6'd18: v = 8'sh85;  6'd19: v = 8'sh91;  6'd20: v = 8'shA5;
      6'd21: v = 8'shBF;  6'd22: v = 8'shDE;
      default: v = 8'sh00;
    endcase
    return v;
  endfunction

  // One synthesizer per code: code+2 clocks per step, 23 steps.
  for (genvar g = 0; g < 2; g++) begin : g_synth
    wire logic running = codes[g] != 8'h00;
    wire logic [8:0] stepLen = {1'b0, codes[g]}
                             + 9'(`DTMG_CODE_OFFSET);
    // Compare with >= so that a code lowered in mid-step ends the
    // step at once instead of letting the counter run round to 511.
    assign stepTick[g] = stepCnt_q[g] >= stepLen - 9'd1;
    assign sineVal[g]  = running ? sineLut(phase_q[g]) : 8'sh00;
    always_ff @(posedge clk) begin
      if (!rst_n || !running) begin
        stepCnt_q[g] <= 9'd0;
        phase_q[g]   <= 6'd0;
      end else if (stepTick[g]) begin
        stepCnt_q[g] <= 9'd0;
        phase_q[g]   <= (phase_q[g] == 6'(`DTMG_STEPS_PER_PER - 1))
                      ? 6'd0 : phase_q[g] + 6'd1;
      end else begin
        stepCnt_q[g] <= stepCnt_q[g] + 9'd1;
      end
    end
  end

  // ********************************************************
  // Summing, melody and pin control
  // ********************************************************
  wire logic bothZero  = (high_group_freq_code_q == 8'h00)
                       & (low_group_freq_code_q == 8'h00);
  wire logic highUsable = high_group_freq_code_q
                        >= `DTMG_SINE_MIN_CODE;
  wire logic signed [15:0] lowScaled =
    sineVal[1] * $signed({1'b0, `DTMG_LOW_GAIN});
  // The product's upper byte is a part-select and thus unsigned; it is
  // made signed again so that negative half-waves keep their sign.
  wire logic signed [9:0] mix = 10'(sineVal[0])
                              + 10'($signed(lowScaled[15:8]));
  wire logic [9:0] dacCode = mix + 10'h200;
  wire logic [DAC_WIDTH-1:0] dacScaled =
    DAC_WIDTH'(dacCode) << (DAC_WIDTH - 10);

  // Square wave: toggles at start of phase and at mid-period.
  // 23 steps split 12/11 gives 52% high time at worst.
  wire logic melodyCodeOk = high_group_freq_code_q
                          >= `DTMG_MELODY_MIN_CODE;
  wire logic squareHigh = phase_q[0] < 6'd12;

  // Mode selection from the enable bit and codes.
  wire dtmg_mode_t mode_d = melody_enable_bit_q ? DTMG_MELODY
                          : bothZero ? DTMG_OFF : DTMG_SINE;

  // Pin drive. In port mode the pin is quasi-bidirectional: it drives
  // low for a cleared flip-flop and is released to its pull-up for a
  // set one. Melody mode drives the pin in both halves of the wave.
  dtmg_pin_t pin_d;
  always_comb begin
    pin_d.pinOut = portFf_q;
    pin_d.pinOe  = ~portFf_q;
    case (mode_d)
      DTMG_MELODY: begin
        if (!melodyCodeOk) begin
          pin_d.pinOut = 1'b1;
          pin_d.pinOe  = 1'b1;
        end else begin
          pin_d.pinOut = squareHigh;
          pin_d.pinOe  = 1'b1;
        end
      end
      default: begin
        pin_d.pinOut = portFf_q;
        pin_d.pinOe  = ~portFf_q;
      end
    endcase
  end

  // Bus answer, captured in the first access cycle and shown in the
  // next one; pready stands for one cycle. Unmapped gives pslverr.
  always_comb begin
    rsp_d.pready  = captureRsp;
    rsp_d.pslverr = captureRsp & ~hitAny;
    rsp_d.prdata  = 32'h0000_0000;
    if (captureRsp) begin
      if (hitHigh) rsp_d.prdata = {24'h0, high_group_freq_code_q};
      if (hitLow)  rsp_d.prdata = {24'h0, low_group_freq_code_q};
      if (hitCtrl) rsp_d.prdata = {30'h0, portFf_q, melody_enable_bit_q};
      if (hitStat) rsp_d.prdata = {27'h0, highUsable, melodyPortPinIn,
                                   ~bothZero, mode_q};
    end
  end

  // Output flops. Every pin and the bus answer come from a register,
  // so the pins never show a glitch of the decode logic.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_q        <= DTMG_OFF;
      apbRsp        <= '0;
      toneLevel     <= '0;
      toneOe        <= 1'b0;
      genPowerOn    <= 1'b0;
      melodyPortPin <= '{pinOut: 1'b1, pinOe: 1'b0};
    end else begin
      mode_q        <= mode_d;
      apbRsp        <= rsp_d;
      toneOe        <= mode_d == DTMG_SINE;
      toneLevel     <= (mode_d == DTMG_SINE) ? dacScaled : '0;
      genPowerOn    <= ~bothZero;
      melodyPortPin <= pin_d;
    end
  end

endmodule
`default_nettype wire

// >>> dv/dtmg_top_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// Port checks for the tone block.
// ****
module dtmg_top_monitor
  import dtmg_pkg::*;
#(parameter int unsigned DAC_WIDTH = 10) (
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire dtmg_pkg::dtmg_apb_req_t apbReq,
  input wire dtmg_pkg::dtmg_apb_rsp_t apbRsp,
  input wire logic                    melodyPortPinIn,
  input wire dtmg_pkg::dtmg_pin_t     melodyPortPin,
  input wire logic [DAC_WIDTH-1:0]    toneLevel,
  input wire logic                    toneOe,
  input wire logic                    genPowerOn
);
  logic [7:0] hiQ;
  logic [7:0] loQ;
  logic       melQ;
  // Access phase and completed write.
  wire logic acc = apbReq.psel & apbReq.penable;
  wire logic wr  = acc & apbReq.pwrite & apbRsp.pready;
  // Shadow of the codes and melody bit, updated at the write edge.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hiQ  <= 8'h00;
      loQ  <= 8'h00;
      melQ <= 1'b0;
    end else if (wr) begin
      case (apbReq.paddr)
        12'h000: hiQ  <= apbReq.pwdata[7:0];
        12'h004: loQ  <= apbReq.pwdata[7:0];
        12'h008: melQ <= apbReq.pwdata[0];
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ready_high: assert property (acc && !apbRsp.pready |=> apbRsp.pready)
    else $error("pready not raised after the first access cycle.");
  a_ready_pulse: assert property (acc && apbRsp.pready |=> !apbRsp.pready)
    else $error("pready stood longer than one cycle.");
  a_unmapped_err: assert property (acc && apbRsp.pready |-> apbRsp.pslverr ==
    !(apbReq.paddr inside {12'h000, 12'h004, 12'h008, 12'h00C}))
    else $error("pslverr does not follow the address map.");
  a_tone_melody: assert property (melQ |=> !toneOe)
    else $error("Tone driven in melody mode.");
  a_tone_sine: assert property (
    !melQ && (hiQ | loQ) != 8'h00 |=> toneOe)
    else $error("Tone not driven in sine mode.");
  a_power_down: assert property ((hiQ | loQ) == 8'h00 |=> !genPowerOn)
    else $error("Generator on with both codes zero.");
  a_power_up: assert property ((hiQ | loQ) != 8'h00 |=> genPowerOn)
    else $error("Generator off with a code set.");
  a_melody_high: assert property (
    melQ && hiQ == 8'h00 |=> melodyPortPin.pinOut)
    else $error("Melody pin not high with zero code.");
  a_melody_drive: assert property (melQ |=> melodyPortPin.pinOe)
    else $error("Melody pin not driven in melody mode.");
  a_level_zero: assert property (!toneOe |-> toneLevel == '0)
    else $error("Tone level nonzero while released.");
endmodule
bind dtmg_top dtmg_top_monitor #(.DAC_WIDTH(DAC_WIDTH)) u_mon (
  .clk(clk), .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp),
  .melodyPortPinIn(melodyPortPinIn), .melodyPortPin(melodyPortPin),
  .toneLevel(toneLevel), .toneOe(toneOe), .genPowerOn(genPowerOn));
`default_nettype wire

// >>> dv/dtmg_line_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// Ringer line with pull-up; measures run lengths.
// ****
module dtmg_line_model
  import dtmg_pkg::*;
(
  input  wire logic                clk,
  input  wire dtmg_pkg::dtmg_pin_t pinDrv,
  output logic                     pinLevel,
  output logic [15:0]              highLen,
  output logic [15:0]              lowLen
);
  logic [15:0] runQ = 16'h0000;
  logic        lastQ = 1'b1;
  // A released pin is pulled high.
  assign pinLevel = pinDrv.pinOe ? pinDrv.pinOut : 1'b1;
  // Record the length of each finished high or low run.
  always @(posedge clk) begin
    if (pinLevel === lastQ) begin
      runQ <= runQ + 16'h0001;
    end else begin
      if (lastQ) highLen <= runQ;
      else lowLen <= runQ;
      runQ  <= 16'h0001;
      lastQ <= pinLevel;
    end
  end
endmodule
`default_nettype wire

// >>> dv/dtmg_top_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "dtmg_defs.svh"
// ****
// Self-checking bench for the tone block.
// ****
module dtmg_top_test;
  import dtmg_pkg::*;
  typedef struct packed {
    logic wr; logic [11:0] ad; logic [31:0] wd, ex; logic er;
  } dtmg_row_t;
  localparam dtmg_row_t ROWS [13] = '{
    '{0, 12'h008, 0, 32'h2, 0}, '{0, 12'h000, 0, 0, 0},
    '{0, 12'h004, 0, 0, 0}, '{0, 12'h00C, 0, 32'h8, 0},
    '{1, 12'h000, 32'hFFFFFF7F, 0, 0}, '{0, 12'h000, 0, 32'h7F, 0},
    '{1, 12'h004, 32'hDD, 0, 0}, '{0, 12'h004, 0, 32'hDD, 0},
    '{1, 12'h000, 32'h5C, 0, 0}, '{0, 12'h000, 0, 32'h5C, 0},
    '{1, 12'h010, 32'h55, 0, 1}, '{0, 12'h010, 0, 0, 1},
    '{0, 12'h00C, 0, 32'h1D, 0}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  dtmg_apb_req_t apbReq = '0;
  dtmg_apb_rsp_t apbRsp;
  dtmg_pin_t pin;
  logic pinLevel, toneOe, genPowerOn, err;
  logic [9:0] toneLevel;
  logic [15:0] highLen, lowLen;
  logic [31:0] rd, lvl, hiPk, loPk;
  int fails = 0, n_checks = 0, cyc = 0;
  dtmg_top #(.DAC_WIDTH(10)) DUT (.clk(clk), .rst_n(rst_n),
    .apbReq(apbReq), .apbRsp(apbRsp), .melodyPortPinIn(pinLevel),
    .melodyPortPin(pin), .toneLevel(toneLevel), .toneOe(toneOe),
    .genPowerOn(genPowerOn));
  dtmg_line_model line (.clk(clk), .pinDrv(pin), .pinLevel(pinLevel),
    .highLen(highLen), .lowLen(lowLen));
  // Clock and a cycle ceiling against hangs.
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      fails++;
      complete_run();
    end
  end
  task automatic chkW(input logic [31:0] got, input logic [31:0] ex);
    n_checks++;
    if (got !== ex) begin
      fails++;
      $display("MISMATCH %0t word %h expected %h", $time, got, ex);
    end
  endtask
  task automatic chkB(input logic got, input logic ex);
    n_checks++;
    if (got !== ex) begin
      fails++;
      $display("MISMATCH %0t flag %b expected %b", $time, got, ex);
    end
  endtask
  // One APB transfer; data taken at the edge with pready high.
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] wd);
    @(posedge clk);
    apbReq <= '{1'b1, 1'b0, w, ad, wd};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    do @(posedge clk); while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask
  // Highest tone level over one period of a code of 0x3D.
  task automatic peak(output logic [31:0] pk);
    pk = 32'h0;
    repeat (1449) begin
      @(posedge clk);
      if (toneLevel > pk) pk = toneLevel;
    end
  endtask
  task automatic complete_run();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ROWS[i]) begin
      apb(ROWS[i].wr, ROWS[i].ad, ROWS[i].wd);
      chkB(err, ROWS[i].er);
      if (!ROWS[i].wr) chkW(rd, ROWS[i].ex);
    end
    apb(1, 12'h004, 0);
    apb(1, 12'h000, 32'h3D);
    repeat (20) @(posedge clk);
    lvl = toneLevel;
    chkB(toneOe, 1);
    chkB(genPowerOn, 1);
    repeat (724) @(posedge clk);
    chkB(toneLevel !== lvl[9:0], 1);
    repeat (725) @(posedge clk);
    chkW(toneLevel, lvl);
    peak(hiPk);
    chkB(hiPk > 32'h200, 1);
    apb(1, 12'h000, 0);
    apb(1, 12'h004, 32'h3D);
    peak(loPk);
    lvl = 32'h200 + (((hiPk - 32'h200) * `DTMG_LOW_GAIN) >> 8);
    chkW(loPk, lvl);
    apb(1, 12'h004, 0);
    apb(1, 12'h008, 32'h2);
    apb(1, 12'h008, 32'h3);
    apb(1, 12'h000, 32'h2);
    repeat (300) @(posedge clk);
    chkB(toneOe, 0);
    chkW(highLen, 48);
    chkW(lowLen, 44);
    apb(1, 12'h000, 0);
    repeat (3) @(posedge clk);
    chkB(pinLevel, 1);
    chkB(pin.pinOe, 1);
    chkB(genPowerOn, 0);
    apb(1, 12'h008, 0);
    repeat (3) @(posedge clk);
    chkB(pin.pinOe, 1);
    chkB(pin.pinOut, 0);
    apb(0, 12'h00C, 0);
    chkW(rd, 0);
    apb(1, 12'h000, 32'h7F);
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    apb(0, 12'h000, 0);
    chkW(rd, 0);
    apb(0, 12'h008, 0);
    chkW(rd, 32'h2);
    complete_run();
  end
endmodule
`default_nettype wire
